// File: sac_pkg.sv
// shared constants and types for the converter sequencing control
package sac_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_US = 20;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned CONV_NS = 65;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RES_W = 10;
  localparam int unsigned SUM_W = 11;
  localparam int unsigned CH_W = 3;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [9:0] MID_LO = 10'h1FF;
  localparam logic [9:0] MID_HI = 10'h200;
  localparam logic [9:0] FULL_CODE = 10'h3FF;
  localparam logic [10:0] SUM_RST = 11'h000;
  localparam logic [2:0] CH_BATTERY = 3'h4;

  typedef enum logic [3:0] {
    SAC_OFF = 4'h1,
    SAC_SETTLE = 4'h2,
    SAC_SAMPLE = 4'h4,
    SAC_CONVERT = 4'h8
  } sac_state_t;

  typedef struct packed {
    logic regulator_enable;
    logic converter_enable;
    logic single_ended_select;
    logic triple_scale_attenuator;
    logic constant_load_enable;
    logic sampling_load_enable;
    logic chopping_enable;
    logic midscale_mute;
    logic polarity_invert;
    logic [2:0] channel_select;
  } sac_ctrl_t;

  typedef struct packed {
    logic regulator_on;
    logic attenuator_on;
    logic load_constant_on;
    logic load_dynamic_on;
    logic sample_on;
    logic mute_on;
    logic invert_on;
    logic [3:0] pad_select;
    logic [2:0] internal_select;
    logic differential;
  } sac_analog_t;
endpackage : sac_pkg

// File: sac_quantizer.sv
// one-step quantizer path: polarity, mute and chopping on the digital side
`timescale 1ns/1ps
module sac_quantizer #(
  parameter int unsigned RES_W = 10
) (
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  input wire logic take,
  input wire logic first_half,
  input wire logic mute,
  input wire logic invert,
  input wire logic [RES_W-1:0] raw_code,
  output logic [RES_W-1:0] code_ff,
  output logic [RES_W:0] sum_ff
);
  wire logic [RES_W-1:0] mid_code;
  wire logic [RES_W-1:0] muted_code;
  wire logic [RES_W-1:0] out_code;
  wire logic [RES_W:0] nxt_sum;

  // mute forces the midpoint; inverting output undoes the inverted input
  assign mid_code = sac_pkg::MID_HI;
  assign muted_code = mute ? mid_code : raw_code;
  assign out_code = invert ? ~muted_code : muted_code;
  // sum restarts on the first half so a chop pair never mixes with stale data
  assign nxt_sum = first_half ? {1'b0, out_code} : sum_ff + {1'b0, out_code};

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      code_ff <= sac_pkg::RESULT_RST;
      sum_ff <= sac_pkg::SUM_RST;
    end
    else if (take)
    begin
      code_ff <= out_code;
      sum_ff <= nxt_sum;
    end
  end
endmodule : sac_quantizer

// File: sac_control.sv
// sequencing control for the general converter: regulator, sampling, conversion
`timescale 1ns/1ps
module sac_control #(
  parameter int unsigned SETTLE_CYC = sac_pkg::SETTLE_CYC,
  parameter int unsigned CONV_CYC = sac_pkg::CONV_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire sac_pkg::sac_ctrl_t ctrl,
  input wire logic start_write,
  input wire logic [sac_pkg::RES_W-1:0] raw_code,
  output sac_pkg::sac_analog_t analog_ff,
  output logic conversion_start_ff,
  output logic regulator_ready_ff,
  output logic [sac_pkg::RES_W-1:0] result_ff,
  output logic [sac_pkg::SUM_W-1:0] chop_sum_ff,
  output logic result_valid_ff
);
  localparam int unsigned SET_W = $clog2(SETTLE_CYC + 1);
  localparam int unsigned CNV_W = $clog2(CONV_CYC + 1);

  logic rst_meta_ff;
  logic rst_sync_b;
  sac_pkg::sac_state_t state_ff;
  sac_pkg::sac_state_t nxt_state;
  logic [SET_W-1:0] settle_ff;
  logic [SET_W-1:0] nxt_settle;
  logic [CNV_W-1:0] conv_ff;
  logic [CNV_W-1:0] nxt_conv;
  logic chop_half_ff;
  logic nxt_chop_half;
  logic [sac_pkg::RES_W-1:0] code_w;
  logic [sac_pkg::SUM_W-1:0] sum_w;
  sac_pkg::sac_analog_t nxt_analog;

  wire logic settled;
  wire logic start_ok;
  wire logic conv_done;
  wire logic chop_second;
  wire logic battery_sel;
  wire logic invert_now;
  wire logic [3:0] pads;

  // decode a channel code to the pads it connects
  function automatic logic [3:0] pad_decode(input logic [2:0] ch, input logic se);
    logic [3:0] p;
    p = 4'h0;
    if (ch[2] == 1'b0)
    begin
      if (se)
        p = 4'h1 << ch[1:0];
      else
        p = ch[0] ? 4'hC : 4'h3;
    end
    return p;
  endfunction : pad_decode

  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_b <= rst_meta_ff;
    end
  end

  assign settled = (settle_ff == SET_W'(SETTLE_CYC));
  // start only counts once settled and tracking; otherwise dropped
  assign start_ok = start_write && ctrl.converter_enable && settled;
  assign conv_done = (state_ff == sac_pkg::SAC_CONVERT) && (conv_ff == CNV_W'(CONV_CYC - 1));
  assign chop_second = ctrl.chopping_enable && chop_half_ff;
  assign battery_sel = (ctrl.channel_select == sac_pkg::CH_BATTERY);
  // chop second half flips polarity on top of the sign control
  assign invert_now = ctrl.polarity_invert ^ chop_second;
  assign pads = pad_decode(ctrl.channel_select, ctrl.single_ended_select);

  // state sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_settle = settle_ff;
    nxt_conv = '0;
    nxt_chop_half = chop_half_ff;
    if (!ctrl.regulator_enable)
    begin
      nxt_state = sac_pkg::SAC_OFF;
      nxt_settle = '0;
      nxt_chop_half = 1'b0;
    end
    else
    begin
      if (!settled)
        nxt_settle = settle_ff + SET_W'(1);
      unique case (state_ff)
        sac_pkg::SAC_OFF:
          nxt_state = sac_pkg::SAC_SETTLE;
        sac_pkg::SAC_SETTLE:
          if (settled && ctrl.converter_enable)
            nxt_state = sac_pkg::SAC_SAMPLE;
        sac_pkg::SAC_SAMPLE:
          if (!ctrl.converter_enable)
            nxt_state = sac_pkg::SAC_SETTLE;
          else if (start_ok)
            nxt_state = sac_pkg::SAC_CONVERT;
        sac_pkg::SAC_CONVERT:
        begin
          nxt_conv = conv_ff + CNV_W'(1);
          if (conv_done)
          begin
            nxt_state = sac_pkg::SAC_SAMPLE;
            nxt_chop_half = ctrl.chopping_enable && !chop_half_ff;
          end
        end
        default:
          nxt_state = sac_pkg::SAC_OFF;
      endcase
    end
  end

  // analog side controls, all registered
  always_comb
  begin
    nxt_analog.regulator_on = ctrl.regulator_enable;
    nxt_analog.attenuator_on = ctrl.triple_scale_attenuator || battery_sel;
    nxt_analog.load_constant_on = ctrl.constant_load_enable;
    nxt_analog.load_dynamic_on = ctrl.sampling_load_enable
                                 && (nxt_state == sac_pkg::SAC_SAMPLE);
    nxt_analog.sample_on = (nxt_state == sac_pkg::SAC_SAMPLE);
    nxt_analog.mute_on = ctrl.midscale_mute;
    nxt_analog.invert_on = invert_now;
    nxt_analog.pad_select = pads;
    nxt_analog.internal_select = ctrl.channel_select[2] ? ctrl.channel_select : 3'h0;
    nxt_analog.differential = !ctrl.single_ended_select;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_ff <= sac_pkg::SAC_OFF;
      settle_ff <= '0;
      conv_ff <= '0;
      chop_half_ff <= 1'b0;
      analog_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      settle_ff <= nxt_settle;
      conv_ff <= nxt_conv;
      chop_half_ff <= nxt_chop_half;
      analog_ff <= nxt_analog;
    end
  end

  // start bit self-clears as the result lands
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      conversion_start_ff <= 1'b0;
      regulator_ready_ff <= 1'b0;
      result_valid_ff <= 1'b0;
    end
    else
    begin
      conversion_start_ff <= (nxt_state == sac_pkg::SAC_CONVERT);
      regulator_ready_ff <= ctrl.regulator_enable && (nxt_settle == SET_W'(SETTLE_CYC));
      result_valid_ff <= conv_done;
    end
  end

  sac_quantizer #(
    .RES_W(sac_pkg::RES_W)
  ) u_quant (
    .clk_sys(clk_sys),
    .rst_sync_b(rst_sync_b),
    .take(conv_done),
    .first_half(!chop_second),
    .mute(ctrl.midscale_mute),
    .invert(invert_now),
    .raw_code(raw_code),
    .code_ff(code_w),
    .sum_ff(sum_w)
  );

  // 10-bit result and 11-bit chop sum; software halves the sum itself
  assign result_ff = code_w;
  assign chop_sum_ff = sum_w;

  chk_start_ignored: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (start_write && !ctrl.converter_enable && state_ff != sac_pkg::SAC_CONVERT)
      |=> !conversion_start_ff)
    else $error("start taken while converter disabled");

  chk_settle_gate: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (state_ff == sac_pkg::SAC_CONVERT) |-> settled)
    else $error("conversion before regulator settled");

  sequence s_launch;
    state_ff == sac_pkg::SAC_SAMPLE && start_ok && ctrl.regulator_enable;
  endsequence
  sequence s_finish;
    ##[1:8] (result_valid_ff && !conversion_start_ff);
  endsequence
  chk_start_clears: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    s_launch |-> s_finish)
    else $error("start did not self-clear with result");

  chk_start_sets: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    s_launch |=> conversion_start_ff)
    else $error("start did not launch conversion");

  chk_dyn_load: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    analog_ff.load_dynamic_on |-> analog_ff.sample_on)
    else $error("dynamic load outside sampling");

  chk_battery_attn: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (ctrl.channel_select == sac_pkg::CH_BATTERY) |=> analog_ff.attenuator_on)
    else $error("battery channel without attenuator");

  chk_mute_mid: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (conv_done && ctrl.midscale_mute && !invert_now) |=> result_ff == sac_pkg::MID_HI)
    else $error("mute did not give mid-scale");

  chk_sample_track: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (ctrl.regulator_enable && ctrl.converter_enable && settled && !start_write
      && state_ff != sac_pkg::SAC_CONVERT) |=> analog_ff.sample_on)
    else $error("enabled converter not sampling");

  chk_diff_pairs: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (!ctrl.single_ended_select && !ctrl.channel_select[2]) |=> $countones(analog_ff.pad_select) == 2)
    else $error("differential mode not a pad pair");

  // start bit is nothing but the registered conversion state
  chk_start_mirror: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    conversion_start_ff == (state_ff == sac_pkg::SAC_CONVERT))
    else $error("start bit differs from conversion state");

  chk_conv_bound: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (state_ff == sac_pkg::SAC_CONVERT) |-> (conv_ff < CNV_W'(CONV_CYC)))
    else $error("conversion ran past its cycle count");

  chk_result_edge: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    result_valid_ff |-> $fell(conversion_start_ff))
    else $error("result landed without start clearing");

  chk_regulator_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !ctrl.regulator_enable |=> (!conversion_start_ff && !regulator_ready_ff))
    else $error("converter active with regulator off");

  chk_const_load: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    ctrl.constant_load_enable |=> analog_ff.load_constant_on)
    else $error("constant load not applied");

  chk_se_flag: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    ctrl.single_ended_select |=> !analog_ff.differential)
    else $error("single-ended select shows differential");

  chk_se_pad: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (ctrl.single_ended_select && !ctrl.channel_select[2])
      |=> $countones(analog_ff.pad_select) == 1)
    else $error("single-ended mode not one pad");

  chk_internal_sel: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    ctrl.channel_select[2]
      |=> (analog_ff.pad_select == 4'h0 && analog_ff.internal_select != 3'h0))
    else $error("internal channel left a pad connected");

  // chop pair: the first result arms the inverted half, the second closes the pair
  sequence s_chop_first;
    ctrl.regulator_enable && conv_done && ctrl.chopping_enable && !chop_half_ff;
  endsequence
  sequence s_chop_second;
    ctrl.regulator_enable && conv_done && chop_second;
  endsequence
  chk_chop_arm: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    s_chop_first |=> chop_half_ff)
    else $error("chop pair did not arm inverted half");

  chk_chop_disarm: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    s_chop_second |=> !chop_half_ff)
    else $error("chop pair did not close");
endmodule : sac_control

// File: sac_analog_model.sv
// behavioural analog core: input pads and internal voltages as ideal codes
`timescale 1ns/1ps
module sac_analog_model #(
  parameter logic [9:0] OFFSET = 10'h003
) (
  input wire logic clk_sys,
  input wire sac_pkg::sac_analog_t analog_ff,
  input wire logic [7:0][9:0] levels,
  output logic [9:0] raw_code
);
  logic [9:0] held_ff;
  logic [9:0] noise_ff = 10'h000;
  logic [9:0] nxt_held;
  logic [9:0] pad_code;
  logic [9:0] signed_code;
  // a differential pair reports its code on the lower pad of the pair
  assign pad_code = analog_ff.pad_select[0] ? levels[0] :
                    analog_ff.pad_select[1] ? levels[1] :
                    analog_ff.pad_select[2] ? levels[2] : levels[3];
  // internal voltages share one level, so their select encoding is free
  assign nxt_held = (analog_ff.internal_select != 3'h0) ? levels[4] : pad_code;
  // input is tracked only while sampling and frozen during conversion
  always_ff @(posedge clk_sys)
  begin
    noise_ff <= noise_ff + 10'h137;
    if (analog_ff.sample_on)
      held_ff <= nxt_held;
  end
  // sign control flips the input ahead of the comparator, so its offset changes sign
  assign signed_code = analog_ff.invert_on ? ~held_ff : held_ff;
  // an unpowered core gives a code that changes every cycle
  assign raw_code = analog_ff.regulator_on ? signed_code + OFFSET : noise_ff;
endmodule : sac_analog_model

// File: tb_top.sv
// self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module tb_top;
  logic clk_sys;
  logic rst_b;
  sac_pkg::sac_ctrl_t ctrl;
  logic start_write;
  logic [9:0] raw_code;
  sac_pkg::sac_analog_t analog_ff;
  logic conv_ff;
  logic ready_ff;
  logic valid_ff;
  logic [9:0] result_ff;
  logic [10:0] chop_sum_ff;
  logic [7:0][9:0] levels;
  logic [31:0] seed;
  int mismatches;
  int samples_checked;
  int cycles;
  int n;
  localparam logic [9:0] CORE_OFS = 10'h003; // comparator offset of the core model

  sac_control #(.SETTLE_CYC(20), .CONV_CYC(7)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ctrl(ctrl), .start_write(start_write),
    .raw_code(raw_code), .analog_ff(analog_ff), .conversion_start_ff(conv_ff),
    .regulator_ready_ff(ready_ff), .result_ff(result_ff), .chop_sum_ff(chop_sum_ff),
    .result_valid_ff(valid_ff)
  );
  sac_analog_model #(.OFFSET(CORE_OFS)) u_core (
    .clk_sys(clk_sys), .analog_ff(analog_ff), .levels(levels), .raw_code(raw_code)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // one start pulse; hold keeps it up into the conversion, which must be ignored
  task automatic convert(input logic [9:0] exp_res, input int hold);
    int k;
    start_write = 1'b1;
    @(negedge clk_sys);
    `CHK(conv_ff, 1'b1)
    `CHK(analog_ff.sample_on, 1'b0)
    `CHK(analog_ff.load_dynamic_on, 1'b0)
    k = hold;
    if (hold != 0)
      @(negedge clk_sys);
    start_write = 1'b0;
    while (valid_ff !== 1'b1 && k < 20)
    begin
      @(negedge clk_sys);
      k++;
    end
    `CHK(k, 7)
    `CHK(result_ff, exp_res)
    `CHK(conv_ff, 1'b0)
    `CHK(analog_ff.sample_on, 1'b1)
    @(negedge clk_sys);
  endtask : convert

  task automatic refused;
    start_write = 1'b1;
    @(negedge clk_sys);
    start_write = 1'b0;
    @(negedge clk_sys);
    `CHK(conv_ff, 1'b0)
  endtask : refused

  initial
  begin
    ctrl = '0;
    start_write = 1'b0;
    rst_b = 1'b0;
    levels = '0;
    seed = 32'h00011E18;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(result_ff, sac_pkg::RESULT_RST)
    `CHK(ready_ff, 1'b0)
    ctrl.converter_enable = 1'b1;
    @(negedge clk_sys);
    refused();
    ctrl.regulator_enable = 1'b1;
    ctrl.constant_load_enable = 1'b1;
    ctrl.sampling_load_enable = 1'b1;
    n = 0;
    while (ready_ff !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n >= 20 && n < 24, 1'b1)
    `CHK(analog_ff.load_constant_on, 1'b1)
    // sampling begins one edge after the regulator reports ready
    @(negedge clk_sys);
    `CHK(analog_ff.load_dynamic_on, 1'b1)
    `CHK(analog_ff.sample_on, 1'b1)
    ctrl.converter_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK(analog_ff.sample_on, 1'b0)
    refused();
    ctrl.converter_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    // every pad in both modes, then the battery and internal channels
    for (int m = 0; m < 2; m++)
      for (int ch = 0; ch < 8; ch++)
      begin
        if (m == 0 && ch > 3)
          continue;
        for (int i = 0; i < 8; i++)
        begin
          seed = lfsr(seed);
          levels[i] = (i > 4) ? levels[4] : seed[9:0];
        end
        ctrl.single_ended_select = m[0];
        ctrl.channel_select = ch[2:0];
        ctrl.triple_scale_attenuator = seed[12];
        repeat (16) @(negedge clk_sys);
        `CHK(analog_ff.differential, ~m[0])
        `CHK(analog_ff.pad_select, m ? 4'(ch < 4 ? 1 << ch : 0) : (ch[0] ? 4'hC : 4'h3))
        `CHK(analog_ff.internal_select != 3'h0, ch > 3)
        `CHK(analog_ff.attenuator_on, seed[12] | (ch == 4))
        convert((m ? levels[ch] : levels[ch[0] * 2]) + CORE_OFS, ch % 2);
      end
    ctrl.midscale_mute = 1'b1;
    // keep the level clear of wrap so offset and sign stay visible
    levels[4] = {2'b01, seed[7:0]};
    repeat (2) @(negedge clk_sys);
    `CHK(analog_ff.mute_on, 1'b1)
    convert(sac_pkg::MID_HI, 0);
    ctrl.midscale_mute = 1'b0;
    ctrl.polarity_invert = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(analog_ff.invert_on, 1'b1)
    convert(levels[4] - CORE_OFS, 0);
    ctrl.polarity_invert = 1'b0;
    ctrl.chopping_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    convert(levels[4] + CORE_OFS, 0);
    convert(levels[4] - CORE_OFS, 0);
    `CHK(chop_sum_ff, {levels[4], 1'b0})
    `CHK(chop_sum_ff[10:1], levels[4])
    ctrl.constant_load_enable = 1'b0;
    ctrl.regulator_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK(analog_ff.load_constant_on, 1'b0)
    `CHK(analog_ff.regulator_on, 1'b0)
    conclude();
  end
endmodule : tb_top
